// ### logic/dio_image_consts.vh
// Constants for the digital I/O process image block.
// Assumes inclusion by bare name from the design files under logic/.
`ifndef DIO_IMAGE_CONSTS_VH
`define DIO_IMAGE_CONSTS_VH

// Digital output image bytes, counted from the end of the analog output data
`define OUT_IDX_SINGLE 8'h00
`define OUT_IDX_DUAL 8'h01
`define OUT_IDX_DUAL_DIAG 8'h02
`define OUT_IDX_DUAL_CODE 8'h03
`define OUT_IDX_QUAD 8'h04
`define OUT_DIGITAL_BYTES 8'h05

// Used control bits of each output variant
`define MASK_SINGLE 8'h01
`define MASK_DUAL 8'h03
`define MASK_QUAD 8'h0f

// Input image byte indices on the read port
`define IN_IDX_WORD_LOW 3'h0
`define IN_IDX_WORD_HIGH 3'h1
`define IN_IDX_SINGLE 3'h2
`define IN_IDX_DUAL_DIAG 3'h3
`define IN_IDX_DUAL_CODE 3'h4

// Field positions
`define POS_MANUAL 0
`define POS_CH1 0
`define POS_CH2 1

// Two-bit channel fault codes
`define CODE_NORMAL 2'h0
`define CODE_OPEN_OR_PLUS 2'h1
`define CODE_GND_OR_OVERLOAD 2'h2

// Reset values
`define RST_BYTE 8'h00
`define RST_BASE 8'h00

`endif

// ### logic/output_channel_latch.v
// Output control byte holder for one digital output variant.
// Assumes a synchronous active-low reset and a one-cycle write strobe.
`include "dio_image_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module output_channel_latch #(
  parameter [7:0] USED_MASK = 8'hff
) (
  input wire mclk_in, // System clock
  input wire rst_n_in, // Synchronous reset, active low
  input wire wr_in, // Write strobe for this byte
  input wire [7:0] data_in, // Output image byte from the coupler
  output reg [7:0] drive_out // Channel drive, unused bits held low
);

  // Store only the used control bits; other positions never reach a channel
  always @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      drive_out <= `RST_BYTE;
    end
    else if (wr_in)
    begin
      drive_out <= data_in & USED_MASK;
    end
  end

endmodule // output_channel_latch

`default_nettype wire

// ### logic/digital_io_process_image.v
// Process image mapping for simple digital input and output channels.
// Assumes the coupler writes output image bytes by address and reads the
// input image by byte index, all synchronous to mclk_in.
`include "dio_image_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module digital_io_process_image (
  input wire mclk_in, // System clock, 125 MHz
  input wire rst_n_in, // Synchronous reset, active low
  input wire [15:0] input_channel_bit_in, // Field states of the sixteen inputs
  input wire manual_mode_in, // Single channel variant in manual operation
  input wire [1:0] dual_overload_in, // Two-channel diag: overload per channel
  input wire [1:0] dual_short_in, // Two-channel diag: short circuit per channel
  input wire [1:0] dual_wire_break_in, // Two-channel diag: broken wire per channel
  input wire [1:0] code_open_in, // Two-bit diag: no load or short to +24 V
  input wire [1:0] code_gnd_in, // Two-bit diag: short to ground or overload
  input wire [7:0] analog_out_bytes_in, // Bytes of analog output data ahead
  input wire out_wr_in, // Output image byte write strobe
  input wire [7:0] out_addr_in, // Output image byte address
  input wire [7:0] out_data_in, // Output image byte data
  input wire in_rd_in, // Input image byte read strobe
  input wire [2:0] in_addr_in, // Input image byte index
  output reg [7:0] image_byte_low_out, // Sixteen-input image, channels 1-8
  output reg [7:0] image_byte_high_out, // Sixteen-input image, channels 9-16
  output reg [7:0] single_status_out, // Single channel status byte
  output reg [7:0] dual_diag_out, // Two-channel fault byte
  output reg [7:0] dual_code_out, // Two-bit fault byte
  output reg [7:0] in_rd_data_out, // Read data of the input image
  output reg in_rd_valid_out, // Read data valid, one cycle
  output reg [7:0] digital_out_base_out, // First digital output byte address
  output reg out_wr_miss_out, // Write hit no digital byte, one cycle
  output wire single_drive_out, // Single channel output drive
  output wire [1:0] dual_drive_out, // Two-channel output drives
  output wire [1:0] dual_diag_drive_out, // Two-channel diag output drives
  output wire [1:0] dual_code_drive_out, // Two-bit diag output drives
  output wire [3:0] quad_drive_out // Four-channel output drives
);

  wire [7:0] rel_addr;
  wire in_digital;
  wire wr_single;
  wire wr_dual;
  wire wr_dual_diag;
  wire wr_dual_code;
  wire wr_quad;
  wire [7:0] single_q;
  wire [7:0] dual_q;
  wire [7:0] dual_diag_q;
  wire [7:0] dual_code_q;
  wire [7:0] quad_q;
  wire [1:0] dual_fault;
  wire [3:0] code_field;
  reg [7:0] next_rd_data;

  // Digital bytes start right after the analog output data
  assign rel_addr = out_addr_in - analog_out_bytes_in;
  assign in_digital = (out_addr_in >= analog_out_bytes_in) && (rel_addr < `OUT_DIGITAL_BYTES);

  // One write strobe per variant byte
  assign wr_single = out_wr_in && in_digital && (rel_addr == `OUT_IDX_SINGLE);
  assign wr_dual = out_wr_in && in_digital && (rel_addr == `OUT_IDX_DUAL);
  assign wr_dual_diag = out_wr_in && in_digital && (rel_addr == `OUT_IDX_DUAL_DIAG);
  assign wr_dual_code = out_wr_in && in_digital && (rel_addr == `OUT_IDX_DUAL_CODE);
  assign wr_quad = out_wr_in && in_digital && (rel_addr == `OUT_IDX_QUAD);

  // Single channel: only bit 0 controls, bits 1 to 7 ignored
  output_channel_latch #(
    .USED_MASK(`MASK_SINGLE)
  ) u_single (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .wr_in(wr_single),
    .data_in(out_data_in),
    .drive_out(single_q)
  );

  // Two channels: bits 0 and 1, bits 2 to 7 ignored
  output_channel_latch #(
    .USED_MASK(`MASK_DUAL)
  ) u_dual (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .wr_in(wr_dual),
    .data_in(out_data_in),
    .drive_out(dual_q)
  );

  // Two-channel diagnostic variant controls
  output_channel_latch #(
    .USED_MASK(`MASK_DUAL)
  ) u_dual_diag (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .wr_in(wr_dual_diag),
    .data_in(out_data_in),
    .drive_out(dual_diag_q)
  );

  // Two-bit diagnostic variant controls, bits 2 to 7 ignored
  output_channel_latch #(
    .USED_MASK(`MASK_DUAL)
  ) u_dual_code (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .wr_in(wr_dual_code),
    .data_in(out_data_in),
    .drive_out(dual_code_q)
  );

  // Four channels: bits 0 to 3, bits 4 to 7 ignored
  output_channel_latch #(
    .USED_MASK(`MASK_QUAD)
  ) u_quad (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .wr_in(wr_quad),
    .data_in(out_data_in),
    .drive_out(quad_q)
  );

  // Channel drives come straight from the latch flip-flops
  assign single_drive_out = single_q[`POS_CH1];
  assign dual_drive_out = dual_q[1:0];
  assign dual_diag_drive_out = dual_diag_q[1:0];
  assign dual_code_drive_out = dual_code_q[1:0];
  assign quad_drive_out = quad_q[3:0];

  // Per-channel fault bit and two-bit fault code
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1)
    begin : g_fault
      // Any of overload, short circuit or broken wire marks the channel
      assign dual_fault[ch] = dual_overload_in[ch] | dual_short_in[ch] | dual_wire_break_in[ch];
      // Ground short or overload takes precedence over open load
      assign code_field[2*ch+1:2*ch] = code_gnd_in[ch] ? `CODE_GND_OR_OVERLOAD :
                                       code_open_in[ch] ? `CODE_OPEN_OR_PLUS :
                                       `CODE_NORMAL;
    end
  endgenerate

  // Sample the input image every cycle; unused positions held at zero
  always @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      image_byte_low_out <= `RST_BYTE;
      image_byte_high_out <= `RST_BYTE;
      single_status_out <= `RST_BYTE;
      dual_diag_out <= `RST_BYTE;
      dual_code_out <= `RST_BYTE;
    end
    else
    begin
      image_byte_low_out <= input_channel_bit_in[7:0];
      image_byte_high_out <= input_channel_bit_in[15:8];
      single_status_out <= {7'h00, manual_mode_in};
      dual_diag_out <= {6'h00, dual_fault};
      dual_code_out <= {4'h0, code_field};
    end
  end

  // Input image read mux; unmapped indices read zero
  always @*
  begin
    next_rd_data = `RST_BYTE;
    case (in_addr_in)
      `IN_IDX_WORD_LOW: next_rd_data = image_byte_low_out;
      `IN_IDX_WORD_HIGH: next_rd_data = image_byte_high_out;
      `IN_IDX_SINGLE: next_rd_data = single_status_out;
      `IN_IDX_DUAL_DIAG: next_rd_data = dual_diag_out;
      `IN_IDX_DUAL_CODE: next_rd_data = dual_code_out;
      default: next_rd_data = `RST_BYTE;
    endcase
  end

  // Register read answer one cycle after the strobe
  always @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      in_rd_data_out <= `RST_BYTE;
      in_rd_valid_out <= 1'b0;
    end
    else
    begin
      in_rd_valid_out <= in_rd_in;
      if (in_rd_in)
      begin
        in_rd_data_out <= next_rd_data;
      end
    end
  end

  // Report the digital base and flag writes that land on no digital byte
  always @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      digital_out_base_out <= `RST_BASE;
      out_wr_miss_out <= 1'b0;
    end
    else
    begin
      digital_out_base_out <= analog_out_bytes_in;
      out_wr_miss_out <= out_wr_in && !in_digital;
    end
  end

endmodule // digital_io_process_image

`default_nettype wire

// ### bench/dio_image_checker.sv
// Assertions on the process image block ports.
// Assumes one clock and a synchronous active-low reset; bound below.
`timescale 1ns/1ps
`default_nettype none
module dio_image_checker (
  input wire logic mclk_in, // Clock
  input wire logic rst_n_in, // Reset
  input wire logic [15:0] input_channel_bit_in, // Field
  input wire logic in_rd_in, // Read
  input wire logic [2:0] in_addr_in, // Index
  input wire logic [7:0] image_byte_low_out, // Low
  input wire logic [7:0] image_byte_high_out, // High
  input wire logic [7:0] in_rd_data_out, // Data
  input wire logic in_rd_valid_out, // Valid
  input wire logic out_wr_in, // Write
  input wire logic [7:0] out_addr_in, // Address
  input wire logic [7:0] out_data_in, // Data
  input wire logic [7:0] analog_out_bytes_in, // Base
  input wire logic [3:0] quad_drive_out, // Drives
  input wire logic out_wr_miss_out // Miss
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  // Write that lands on the four-channel byte
  wire logic quad_hit = out_wr_in && out_addr_in >= analog_out_bytes_in && out_addr_in - analog_out_bytes_in == 8'h04;
  sequence s_rd(logic [2:0] i);
    in_rd_in && in_addr_in == i;
  endsequence
  a_word_map: assert property (1 |=> {image_byte_high_out, image_byte_low_out} == $past(input_channel_bit_in))
    else $error("input word misplaced");
  a_low_read: assert property (s_rd(3'h0) |=> in_rd_data_out == $past(image_byte_low_out))
    else $error("low byte read wrong");
  a_high_read: assert property (s_rd(3'h1) |=> in_rd_valid_out && in_rd_data_out == $past(image_byte_high_out))
    else $error("high byte read wrong");
  a_read_pulse: assert property (in_rd_valid_out == $past(in_rd_in))
    else $error("read valid wrong");
  a_quad_write: assert property (quad_hit |=> quad_drive_out == $past(out_data_in[3:0]))
    else $error("quad drive wrong");
  a_quad_hold: assert property (!quad_hit |=> $stable(quad_drive_out))
    else $error("quad drive moved");
  a_miss_low: assert property (out_wr_in && out_addr_in < analog_out_bytes_in |=> out_wr_miss_out)
    else $error("miss not flagged");
  a_hit_quiet: assert property (quad_hit |=> !out_wr_miss_out)
    else $error("false miss");
endmodule // dio_image_checker
bind digital_io_process_image dio_image_checker dio_image_checker_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
  .input_channel_bit_in(input_channel_bit_in), .in_rd_in(in_rd_in), .in_addr_in(in_addr_in),
  .image_byte_low_out(image_byte_low_out), .image_byte_high_out(image_byte_high_out),
  .in_rd_data_out(in_rd_data_out), .in_rd_valid_out(in_rd_valid_out), .out_wr_in(out_wr_in),
  .out_addr_in(out_addr_in), .out_data_in(out_data_in), .analog_out_bytes_in(analog_out_bytes_in),
  .quad_drive_out(quad_drive_out), .out_wr_miss_out(out_wr_miss_out));
`default_nettype wire

// ### bench/coupler_model.sv
// Coupler model: writes output image bytes, reads input image bytes.
// Assumes the block samples on the rising clock; drives at falling edges.
`timescale 1ns/1ps
`default_nettype none
module coupler_model (
  input wire logic mclk_in, // Clock
  output logic wr_out, // Write strobe
  output logic [7:0] wa_out, // Write address
  output logic [7:0] wd_out, // Write data
  output logic rd_out, // Read strobe
  output logic [2:0] ra_out, // Read index
  input wire logic [7:0] rdata_in, // Read data
  input wire logic rvalid_in // Read valid
);
  initial {wr_out, wa_out, wd_out, rd_out, ra_out} = '0;
  // One-cycle write; idle address and data show inverted values
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_in);
    {wr_out, wa_out, wd_out} = {1'b1, a, d};
    @(negedge mclk_in);
    {wr_out, wa_out, wd_out} = {1'b0, ~a, ~d};
  endtask
  // Read data and valid flag are both returned to the bench
  task rd(input logic [2:0] i, output logic [8:0] d);
    @(negedge mclk_in);
    {rd_out, ra_out} = {1'b1, i};
    @(negedge mclk_in);
    {rd_out, ra_out} = {1'b0, ~i};
    d = {rvalid_in, rdata_in};
  endtask
endmodule // coupler_model
`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench of the process image block against a bench model.
// Assumes design and coupler model compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk_in = 0, rst_n_in = 0, man = 0, wr, rd, rv, miss, s1;
  logic [15:0] fin = 0;
  logic [1:0] ov = 0, sh = 0, wb = 0, op = 0, gn = 0, d2, dd, dc;
  logic [7:0] ana = 0, wa, wd, lo, hi, st, dg, cd, rdat, base, a, drv[5], im[8];
  logic [2:0] ra;
  logic [3:0] q;
  logic [8:0] got;
  logic [31:0] x = 32'h67ec, r;
  int n_errors = 0, compares = 0, i, k;
  always #4 mclk_in = ~mclk_in;
  digital_io_process_image digital_io_process_image_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .input_channel_bit_in(fin), .manual_mode_in(man), .dual_overload_in(ov), .dual_short_in(sh),
    .dual_wire_break_in(wb), .code_open_in(op), .code_gnd_in(gn), .analog_out_bytes_in(ana),
    .out_wr_in(wr), .out_addr_in(wa), .out_data_in(wd), .in_rd_in(rd), .in_addr_in(ra),
    .image_byte_low_out(lo), .image_byte_high_out(hi), .single_status_out(st), .dual_diag_out(dg),
    .dual_code_out(cd), .in_rd_data_out(rdat), .in_rd_valid_out(rv), .digital_out_base_out(base),
    .out_wr_miss_out(miss), .single_drive_out(s1), .dual_drive_out(d2), .dual_diag_drive_out(dd),
    .dual_code_drive_out(dc), .quad_drive_out(q));
  coupler_model coupler_model_inst (.mclk_in(mclk_in), .wr_out(wr), .wa_out(wa), .wd_out(wd),
    .rd_out(rd), .ra_out(ra), .rdata_in(rdat), .rvalid_in(rv));
  // Random source, bench model and reporting
  function automatic logic [31:0] rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic logic [1:0] code(input logic g, input logic o);
    return g ? 2'h2 : (o ? 2'h1 : 2'h0);
  endfunction
  task chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  task end_of_test;
    $display("Counts: %0d compares, %0d errors", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Watchdog against a hung run
  initial
  begin
    #100000;
    n_errors++;
    end_of_test;
  end
  // Main sequence: input image, then output writes
  initial
  begin
    repeat (20) @(negedge mclk_in);
    rst_n_in = 1;
    chk({q, dc, dd, d2, s1, miss, rv}, 16'h0);
    chk({hi, lo}, 16'h0);
    chk({st, dg}, 16'h0);
    chk({cd, rdat}, 16'h0);
    chk({8'h0, base}, 16'h0);
    for (i = 0; i < 16; i++)
    begin
      r = rnd();
      @(negedge mclk_in);
      {fin, man, ov, sh, wb} = r[22:0];
      {op, gn} = i[3:0];
      im = '{fin[7:0], fin[15:8], {7'h0, man}, {6'h0, ov | sh | wb},
        {4'h0, code(gn[1], op[1]), code(gn[0], op[0])}, 8'h0, 8'h0, 8'h0};
      @(negedge mclk_in);
      chk({hi, lo}, {im[1], im[0]});
      chk({st, dg}, {im[2], im[3]});
      chk({8'h0, cd}, {8'h0, im[4]});
      for (k = 0; k < 8; k++)
      begin
        coupler_model_inst.rd(k[2:0], got);
        chk({7'h0, got}, {8'h1, im[k]});
      end
    end
    $display("Test input image done");
    r = rnd();
    ana = {2'h0, r[5:0]} | 8'h01;
    foreach (drv[j]) drv[j] = 8'h0;
    @(negedge mclk_in);
    @(negedge mclk_in);
    chk({8'h0, base}, {8'h0, ana});
    for (i = 0; i < 21; i++)
    begin
      r = rnd();
      k = i % 7;
      a = (k == 6) ? ana - 8'h01 : ana + k[7:0];
      coupler_model_inst.wr(a, r[7:0]);
      if (k < 5)
        drv[k] = r[7:0] & ((k == 0) ? 8'h01 : ((k == 4) ? 8'h0f : 8'h03));
      chk({15'h0, miss}, {15'h0, k > 4});
      chk({q, dc, dd, d2, s1}, {drv[4][3:0], drv[3][1:0], drv[2][1:0], drv[1][1:0], drv[0][0]});
    end
    $display("Test output writes done");
    // Mid-run reset clears every drive, then a first write lands at once
    rst_n_in = 0;
    repeat (2) @(negedge mclk_in);
    rst_n_in = 1;
    chk({3'h0, q, dc, dd, d2, s1, miss, rv}, 16'h0);
    chk({8'h0, base}, 16'h0);
    coupler_model_inst.wr(ana + 8'h04, 8'hff);
    chk({4'h0, q, dc, dd, d2, s1, miss}, 16'h0f00);
    chk({8'h0, base}, {8'h0, ana});
    $display("Test mid-run reset done");
    end_of_test;
  end
endmodule // testbench
`default_nettype wire
